//--- verilog/pao_top.sv
`timescale 1ns/100ps
// Overview of operation
// [R01] Format select low inverts top bit (two's complement), high keeps it.
// [R02] Data pins driven only while active-low output enable is low.
// [R03] Receiver latches each word on rising edge of data valid strobe.
// [R04] Overflow flag high when sample exceeded range either way.
// [R05] New sample starts on rising edge of the encode pair.
// [R06] Output bit zero is LSB, bit eleven is MSB.
// [R07] Four stages; result appears five encode cycles after sampling.
// [R08] Encode high phase when true input exceeds complement, else low.
// [R09] Track while low, freeze at rising edge, first stage acquires.
// [R10] Adjacent stages alternate, residue advances one stage per half-cycle.
// [R11] Stage partial results delayed to align, then merged in correction.
// [R12] Overflow flag pipelined with same latency as the data word.
module pao_top
    import pao_pkg::*;
#(
    parameter int W   = RES_W,   // Result width
    parameter int LAT = LAT_CYC  // Encode cycles of latency
) (
    input  wire logic         clk,             // 40 MHz system clock
    input  wire logic         rst,             // Sync reset, high
    input  wire logic         enc_p,           // Encode pair, true side
    input  wire logic         enc_n,           // Encode pair, complement
    input  wire logic [W-1:0] analog_code,     // Ideal sampled input code
    input  wire logic         analog_over,     // Input above full scale
    input  wire logic         analog_under,    // Input below full scale
    input  wire logic         top_bit_invert_select, // Format select
    input  wire logic         out_en_n,        // Output enable, low
    output logic [W-1:0]      result_word_o,   // Result data pins
    output logic [W-1:0]      result_word_oe,  // Pin drive enables
    output logic              range_overflow_flag, // Over/under flag
    output logic              data_valid_strobe    // Data valid out
);
    // Latency walk of one sample, in detected encode edges:
    //   rise 0        tracked code frozen into slot 0 of the stage pipe
    //   rise 4        word leaves the last slot into the skid buffer
    //   fall after 4  buffer drains into the hold register
    //   rise 5        hold register loads the pins, flag with it
    //   fall after 5  strobe rises a clock later; data stood meanwhile
    // The buffer never fills: one push per rise, one pop per fall.
    // Edge detection costs about three clocks, so encode half periods
    // below two clocks are not followed; the price of the pin filter.
    // Half-cycles spent in the stage pipe; the skid buffer and the
    // hold register add the last encode cycle of latency
    localparam int HALF = 2 * LAT - 2;

    typedef enum logic [1:0] {
        PH_LOW  = 2'b00,
        PH_RISE = 2'b01,
        PH_HIGH = 2'b11,
        PH_FALL = 2'b10
    } pao_phase_e;

    // All module state but the skid buffer's lives in one register; the pin filters sit
    // here too so reset clears them with the rest
    typedef struct packed {
        logic [2:0]               enc_sync;
        pao_phase_e               phase;
        logic [W-1:0]             track;
        logic                     track_of;
        logic [HALF-1:0][W:0]     pipe;
        logic [HALF-1:0]          pipe_vld;
        logic [W-1:0]             dout;
        logic [W-1:0]             doe;
        logic                     of;
        logic                     strobe;
        logic                     hold_vld;
        logic [W:0]               hold;
        // Pin synchronisers and their filtered levels
        logic [2:0]               oen_sync;
        logic                     oen_lvl;
        logic [2:0]               fmt_sync;
        logic                     fmt_lvl;
        logic [2:0]               ovr_sync;
        logic                     ovr_lvl;
        logic [2:0]               und_sync;
        logic                     und_lvl;
        logic [2:0][W-1:0]        code_sync;
        logic [W-1:0]             code_lvl;
    } pao_st_s;

    pao_st_s   st_r;
    pao_st_s   st_nxt;
    logic      enc_lvl;
    logic      drain_vld;
    logic [W:0] drain_dat;
    logic      drain_rdy;

    pao_word_if #(.W(W + 1)) word_if ();

    // Correction merge: format the top bit; out of range samples are clamped while tracking
    function automatic logic [W-1:0] pao_fmt(input logic [W-1:0] c,
                                             input logic inv_n);
        logic [W-1:0] r;
        r = c;
        r[W-1] = c[W-1] ^ ~inv_n; // [R01] [R06]
        return r;
    endfunction : pao_fmt

    // Pin filter: a new level counts once the 2nd and 3rd stages agree
    function automatic logic pao_agree(input logic [2:0] s,
                                       input logic       cur);
        // Hold the old level while the stages disagree
        return (s[2] == s[1]) ? s[2] : cur;
    endfunction : pao_agree

    // Same filter for a whole bus; a code still settling is skipped
    // so bits from two different codes never reach the sampler
    function automatic logic [W-1:0] pao_agree_w(
        input logic [2:0][W-1:0] s,
        input logic [W-1:0]      cur);
        // Hold the old word while the stages disagree
        return (s[2] == s[1]) ? s[2] : cur;
    endfunction : pao_agree_w

    // Differential pair reduced to one level before sampling
    assign enc_lvl = enc_p & ~enc_n; // [R08]

    // Full half-cycle pipeline; buffer always drains on a strobe
    assign word_if.valid = st_r.pipe_vld[HALF-1] && st_r.phase == PH_RISE;
    assign word_if.data  = st_r.pipe[HALF-1];
    assign drain_rdy     = (st_r.phase == PH_FALL) && !st_r.hold_vld;

    pao_buf2 #(.W(W + 1)) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_p      (word_if),
        .out_valid (drain_vld),
        .out_data  (drain_dat),
        .out_ready (drain_rdy)
    );

    // Phase tracking, sampling, pipeline shift and output drive
    always_comb begin
        st_nxt = st_r;
        st_nxt.enc_sync = {st_r.enc_sync[1:0], enc_lvl};
        // Control pins, filtered before use
        st_nxt.oen_sync  = {st_r.oen_sync[1:0], out_en_n};
        st_nxt.oen_lvl   = pao_agree(st_r.oen_sync, st_r.oen_lvl);
        st_nxt.fmt_sync  = {st_r.fmt_sync[1:0], top_bit_invert_select};
        st_nxt.fmt_lvl   = pao_agree(st_r.fmt_sync, st_r.fmt_lvl);
        // Range pins travel with the code they qualify
        st_nxt.ovr_sync  = {st_r.ovr_sync[1:0], analog_over};
        st_nxt.ovr_lvl   = pao_agree(st_r.ovr_sync, st_r.ovr_lvl);
        st_nxt.und_sync  = {st_r.und_sync[1:0], analog_under};
        st_nxt.und_lvl   = pao_agree(st_r.und_sync, st_r.und_lvl);
        // Code bus filtered as one word so a torn code is never taken
        st_nxt.code_sync = {st_r.code_sync[1:0], analog_code};
        st_nxt.code_lvl  = pao_agree_w(st_r.code_sync, st_r.code_lvl);

        case (st_r.phase)
            PH_LOW: begin
                if (st_r.enc_sync[2] && st_r.enc_sync[1]) begin
                    st_nxt.phase = PH_RISE;
                end
            end
            PH_RISE: begin
                st_nxt.phase = PH_HIGH;
            end
            PH_HIGH: begin
                if (!st_r.enc_sync[2] && !st_r.enc_sync[1]) begin
                    st_nxt.phase = PH_FALL;
                end
            end
            PH_FALL: begin
                st_nxt.phase = PH_LOW;
            end
            default: begin
                st_nxt.phase = PH_LOW;
            end
        endcase
        // Input tracked while encode low; the last value seen before
        // the detected rise becomes the sample
        if (st_r.phase == PH_LOW) begin
            st_nxt.track    = st_r.ovr_lvl ? CODE_MAX : // [R09]
                              st_r.und_lvl ? CODE_MIN : st_r.code_lvl;
            st_nxt.track_of = st_r.ovr_lvl | st_r.und_lvl; // [R04]
        end
        // Each edge moves every residue one stage on
        if (st_r.phase == PH_RISE || st_r.phase == PH_FALL) begin
            st_nxt.pipe[0]     = {st_r.track_of, st_r.track}; // [R05] [R12]
            st_nxt.pipe_vld[0] = (st_r.phase == PH_RISE);
            for (int i = 1; i < HALF; i++) begin
                st_nxt.pipe[i]     = st_r.pipe[i-1]; // [R10] [R11]
                st_nxt.pipe_vld[i] = st_r.pipe_vld[i-1];
            end
        end
        // Word reaches the pins at the rising edge LAT cycles on
        if (drain_vld && drain_rdy) begin
            st_nxt.hold_vld = 1'b1;
            st_nxt.hold     = drain_dat; // [R07]
        end
        if (st_r.phase == PH_RISE && st_r.hold_vld) begin
            st_nxt.hold_vld = 1'b0;
            st_nxt.dout     = pao_fmt(st_r.hold[W-1:0],
                                      st_r.fmt_lvl);
            st_nxt.of       = st_r.hold[W]; // [R12]
        end
        // Strobe rises half a cycle after the data changes
        st_nxt.strobe = (st_r.phase == PH_HIGH) ? 1'b0 :
                        (st_r.phase == PH_FALL) ? 1'b1 : st_r.strobe; // [R03]
        st_nxt.doe = {W{~st_r.oen_lvl}}; // [R02]
    end

    // One register stage for all state outside the skid buffer; reset clears the pins' word, so
    // the words strobed out before the first sample arrives are zero
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r       <= '0;
            st_r.phase <= PH_LOW;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pins come straight from the state register
    assign result_word_o       = st_r.dout;
    assign result_word_oe      = st_r.doe;
    assign range_overflow_flag = st_r.of;
    assign data_valid_strobe   = st_r.strobe;
endmodule : pao_top

//--- include/pao_pkg.sv
package pao_pkg;
    // Result word geometry
    localparam int RES_W          = 12;
    localparam int RES_MSB        = RES_W - 1;
    // Encode cycles from sample to output word
    localparam int LAT_CYC        = 5;
    // Pipeline stages in the converter core
    localparam int NUM_STG        = 4;
    // Bits resolved per stage (last stage resolves the remainder)
    localparam int STG_BITS       = 3;
    // Reset values
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    localparam logic             BIT_RST = 1'b0;
    // Full-scale codes in offset binary
    localparam logic [RES_W-1:0] CODE_MAX = 12'hfff;
    localparam logic [RES_W-1:0] CODE_MIN = 12'h000;
endpackage : pao_pkg

//--- include/pao_word_if.sv
`timescale 1ns/100ps
// Word path between capture pipeline and output buffer
interface pao_word_if #(parameter int W = 13);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : pao_word_if

//--- verilog/pao_buf2.sv
`timescale 1ns/100ps
// Two-entry skid buffer; a stalled drain side loses no word
module pao_buf2
    import pao_pkg::*;
#(
    parameter int W = 13
) (
    input  wire logic clk,          // System clock
    input  wire logic rst,          // Sync reset, high
    pao_word_if.dst   in_p,         // Filling side
    output logic      out_valid,    // Word available
    output logic [W-1:0] out_data,  // Head word
    input  wire logic out_ready     // Drain accepts
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              rd;
        logic              wr;
        logic [1:0]        cnt;
    } pao_buf_s;

    pao_buf_s st_r;
    pao_buf_s st_nxt;
    logic     push;
    logic     pop;

    // Full means both entries hold words
    assign in_p.ready = (st_r.cnt != 2'h2);
    assign out_valid  = (st_r.cnt != 2'h0);
    assign out_data   = st_r.mem[st_r.rd];
    assign push       = in_p.valid && in_p.ready;
    assign pop        = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_p.data;
            st_nxt.wr           = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 2'h1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : pao_buf2

//--- tb/pao_props.sv
`timescale 1ns/100ps
// Pin checker; encode is seen the way the core sees it, on clk
module pao_props
    import pao_pkg::*;
#(
    parameter int W = RES_W
) (
    input wire logic         clk,                 // System clock
    input wire logic         rst,                 // Sync reset
    input wire logic         enc_p,               // Encode true
    input wire logic         enc_n,               // Encode complement
    input wire logic         out_en_n,            // Output enable
    input wire logic [W-1:0] result_word_o,       // Data pins
    input wire logic [W-1:0] result_word_oe,      // Drive enables
    input wire logic         range_overflow_flag, // Flag pin
    input wire logic         data_valid_strobe    // Strobe pin
);
    wire encode_clock_pair = enc_p & ~enc_n;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A fall must be answered by a fresh strobe rise
    sequence s_fall_seen;
        $fell(encode_clock_pair) ##[1:6] $rose(data_valid_strobe);
    endsequence
    // Cycles the enable pin has held still; the core filters it first
    logic [2:0] oen_age;
    always_ff @(posedge clk) begin
        if (rst || $changed(out_en_n)) begin
            oen_age <= 3'h0;
        end else if (oen_age != 3'h7) begin
            oen_age <= oen_age + 3'h1;
        end
    end
    oe_follow_a: assert property (oen_age >= 3'h5 &&
        $stable(out_en_n)
        |-> result_word_oe == {W{!out_en_n}}) else $error("oe wrong");
    strobe_data_a: assert property ($rose(data_valid_strobe)
        |-> $stable(result_word_o)) else $error("word moved at strobe");
    flag_clamp_a: assert property (range_overflow_flag
        |-> result_word_o inside {12'h000, 12'hfff, 12'h7ff, 12'h800})
        else $error("flagged word not clamped");
    strobe_fall_a: assert property ($rose(encode_clock_pair) ##1 data_valid_strobe
        |-> ##[1:6] $fell(data_valid_strobe)) else $error("no strobe fall");
    strobe_rise_a: assert property ($fell(encode_clock_pair) |-> s_fall_seen)
        else $error("no strobe rise");
    one_word_a: assert property ($changed(result_word_o)
        |=> $stable(result_word_o)[*3]) else $error("word unstable");
    strobe_gap_a: assert property ($rose(data_valid_strobe)
        |=> (!$rose(data_valid_strobe))[*6]) else $error("strobe too fast");
    flag_hold_a: assert property ($changed(range_overflow_flag)
        |=> $stable(range_overflow_flag)[*3]) else $error("flag unstable");
endmodule : pao_props
bind pao_top pao_props #(.W(W)) u_props (.clk(clk), .rst(rst),
    .enc_p(enc_p), .enc_n(enc_n), .out_en_n(out_en_n),
    .result_word_o(result_word_o), .result_word_oe(result_word_oe),
    .range_overflow_flag(range_overflow_flag),
    .data_valid_strobe(data_valid_strobe));

//--- tb/pao_cap.sv
`timescale 1ns/100ps
// Receiving logic: latches pins on each strobe rise
module pao_cap
    import pao_pkg::*;
(
    input  wire logic             clk,      // System clock
    input  wire logic [RES_W-1:0] wd,       // Pin driven values
    input  wire logic [RES_W-1:0] oe,       // Pin drive enables
    input  wire logic             fl,       // Flag pin
    input  wire logic             st,       // Strobe pin
    output logic      [RES_W-1:0] cap_word, // Last word latched
    output logic                  cap_flag, // Flag latched with it
    output int                    cap_n     // Words latched
);
    logic st_d = 1'b0;
    // Released pins float; inverse shown so stale data never passes
    wire [RES_W-1:0] lvl = ~(wd ^ oe);
    initial cap_n = 0;
    // Latch on strobe rise only
    always @(posedge clk) begin
        st_d <= st;
        if (st && !st_d) begin
            cap_word <= lvl;
            cap_flag <= fl;
            cap_n    <= cap_n + 1;
        end
    end
endmodule : pao_cap

//--- tb/pao_top_bench.sv
`timescale 1ns/100ps
// Single samples go in; the captured word is judged five rises later
module pao_top_bench;
    import pao_pkg::*;
    logic             clk = 0, rst = 1, encode_clock_pair = 0, ov = 0, un = 0;
    logic             inv = 1, oen = 0, fl, st, cf;
    logic [RES_W-1:0] code = 12'h000, wd, oe, cw;
    int               cn, n_errors = 0, total_checks = 0;
    initial forever #12.5 clk = ~clk;
    // Encode at 200 ns, offset so its edges sit off the clk edges
    initial begin
        #37;
        forever #100 encode_clock_pair = ~encode_clock_pair;
    end
    pao_top DUT (.clk(clk), .rst(rst), .enc_p(encode_clock_pair), .enc_n(~encode_clock_pair),
        .analog_code(code), .analog_over(ov), .analog_under(un),
        .top_bit_invert_select(inv), .out_en_n(oen), .result_word_o(wd),
        .result_word_oe(oe), .range_overflow_flag(fl),
        .data_valid_strobe(st));
    pao_cap CAP (.clk(clk), .wd(wd), .oe(oe), .fl(fl), .st(st),
        .cap_word(cw), .cap_flag(cf), .cap_n(cn));
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Filler after the freeze makes a wrong latency show up
    task automatic send(input logic [11:0] c, input logic o, u, f);
        logic [11:0] w;
        int          k;
        w = o ? 12'hfff : (u ? 12'h000 : c);
        w[RES_MSB] = w[RES_MSB] ^ !f;
        @(negedge encode_clock_pair);
        @(negedge clk);
        {code, ov, un, inv} = {c, o, u, f};
        @(posedge encode_clock_pair);
        repeat (6) @(negedge clk);
        {code, ov, un} = {c ^ 12'h555, 2'b00};
        repeat (5) @(posedge encode_clock_pair);
        // The previous word's strobe lands before this fall, ours after
        @(negedge encode_clock_pair);
        k = cn;
        for (int i = 0; i < 40 && cn == k; i++) @(negedge clk);
        if (cn == k) begin
            n_errors++;
            stop_test();
        end
        chk({cf, cw}, {o | u, w});
    endtask : send
    task automatic t_format;
        send(12'h001, 0, 0, 1);
        send(12'h001, 0, 0, 0);
        send(12'h9ab, 0, 0, 0);
        send(12'h9ab, 0, 0, 1);
        $display("format test done");
    endtask : t_format
    task automatic t_range;
        send(12'h456, 1, 0, 1);
        send(12'h456, 0, 1, 1);
        send(12'h456, 1, 0, 0);
        $display("range test done");
    endtask : t_range
    task automatic t_oe;
        // Enable pin is filtered in the core: allow five clocks and more
        oen = 1;
        repeat (8) @(negedge clk);
        chk({1'b0, oe}, 13'h0000);
        oen = 0;
        repeat (8) @(negedge clk);
        chk({1'b0, oe}, 13'h0fff);
        $display("enable test done");
    endtask : t_oe
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        t_format();
        t_range();
        t_oe();
        stop_test();
    end
endmodule : pao_top_bench
